/* src/srhp_device.sv */
// Device end: shadow register, register file, indirect space and queue transfer register.
// Assumes CPU strobes already synchronous to clk_sys.
// Refused accesses during power down still end their stretch, so the CPU never hangs.
`timescale 1ns/1ps
`default_nettype none
module srhp_device
    import srhp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    srhp_if.dev              bus,
    input  wire logic        powerDownPin,
    input  wire logic [31:0] rxQueueData,
    input  wire logic        rxQueueValid,
    output logic             rxQueuePop,
    output logic [31:0]      txQueueData,
    output logic             txQueuePush,
    output logic [31:0]      asyncIrqEnable
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] shadow_ff;
    logic [31:0] regFile_ff [0:63];
    logic [31:0] indMem_ff [0:IND_DEPTH-1];
    logic [31:0] txHold_ff;
    logic        txHoldFull_ff;
    logic [7:0]  latAddr_ff;
    logic        active_ff;
    logic [4:0]  waitCnt_ff;
    logic        done_ff;
    logic [7:0]  effAddr;
    logic [7:0]  regOfs;
    logic [1:0]  lane;
    logic        accessOn;
    logic        accessStart;
    logic        allowed;
    logic        poweredDown;
    logic [31:0] targetRead;
    logic [5:0]  indIndex;
    logic        directHit;

    // Address comes from the latch in multiplexed mode, else straight from pins
    assign effAddr     = bus.muxMode ? latAddr_ff : bus.addr[7:0];
    assign regOfs      = {effAddr[7:2], 2'b00};
    assign lane        = srhp_lane(effAddr[1:0], bus.mode16);
    assign accessOn    = !bus.chipSel_n && (!bus.read_n || !bus.write_n);
    assign accessStart = accessOn && !active_ff;
    assign poweredDown = powerDownPin || regFile_ff[OFS_POWER_DOWN[7:2]][0];
    assign allowed     = !poweredDown || (regOfs == OFS_POWER_DOWN);

    // Indirect slot from the index register; direct hits skip the queue and window offsets
    assign indIndex    = regFile_ff[OFS_IND_INDEX[7:2]][5:0];
    assign directHit   = regOfs != OFS_IND_DATA && regOfs != OFS_TX_QUEUE && regOfs != OFS_RX_QUEUE;

    // Latch address on ALE in multiplexed mode
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            latAddr_ff <= 8'h00;
        end else if (bus.addrLatch) begin
            latAddr_ff <= bus.addr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combinational byte or word pick from the shadow register
    // Lanes follow the address pins directly outside multiplexed mode, else the latched address, so glue can toggle them within one read
    always_comb begin
        bus.dataFromDev = 16'h0000;
        if (bus.mode16) begin
            bus.dataFromDev = lane[1] ? shadow_ff[15:0] : shadow_ff[31:16];
        end else begin
            unique case (lane)
                2'h0: bus.dataFromDev = {8'h00, shadow_ff[31:24]};
                2'h1: bus.dataFromDev = {8'h00, shadow_ff[23:16]};
                2'h2: bus.dataFromDev = {8'h00, shadow_ff[15:8]};
                2'h3: bus.dataFromDev = {8'h00, shadow_ff[7:0]};
            endcase
        end
    end

    // Drive the data bus only while the read strobe is low
    assign bus.dataFromDevEn = !bus.chipSel_n && !bus.read_n;

    // Target register selection for a snapshot
    always_comb begin
        if (regOfs == OFS_IND_DATA) begin
            targetRead = indMem_ff[indIndex];
        end else if (regOfs == OFS_RX_QUEUE) begin
            targetRead = rxQueueValid ? rxQueueData : 32'h00000000;
        end else begin
            targetRead = regFile_ff[regOfs[7:2]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access tracking and cycle stretch counter
    // Fifteen counted cycles after the first edge cover the 120 ns update window
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            active_ff  <= 1'b0;
            waitCnt_ff <= 5'h00;
            done_ff    <= 1'b0;
        end else if (!accessOn) begin
            active_ff  <= 1'b0;
            waitCnt_ff <= 5'h00;
            done_ff    <= 1'b0;
        end else if (accessStart) begin
            active_ff  <= 1'b1;
            waitCnt_ff <= bus.addr[8] ? 5'(STRETCH_CYC - 1) : 5'(FAST_CYC - 1);
            done_ff    <= 1'b0;
        end else if (waitCnt_ff != 5'h00) begin
            waitCnt_ff <= waitCnt_ff - 5'h01;
        end else begin
            done_ff <= 1'b1;
        end
    end
    assign bus.hostCycleStretch = accessOn && !done_ff;

    // Shadow register: snapshots, byte or word loads, reset pattern
    // Loads happen once, on the first edge, so a long strobe never repeats them
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shadow_ff <= SHADOW_PRESET;
        end else if (accessStart && allowed && !bus.read_n) begin
            if (bus.addr[8]) begin
                shadow_ff <= targetRead;
            end
        end else if (accessStart && allowed && !bus.write_n) begin
            // Untouched lanes keep their value, later writes overwrite
            if (bus.mode16) begin
                if (lane[1]) shadow_ff[15:0] <= bus.dataFromHost;
                else shadow_ff[31:16] <= bus.dataFromHost;
            end else begin
                unique case (lane)
                    2'h0: shadow_ff[31:24] <= bus.dataFromHost[7:0];
                    2'h1: shadow_ff[23:16] <= bus.dataFromHost[7:0];
                    2'h2: shadow_ff[15:8]  <= bus.dataFromHost[7:0];
                    2'h3: shadow_ff[7:0]   <= bus.dataFromHost[7:0];
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commit value: shadow with the lane of this write merged in
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [15:0] d,
                                          input logic [1:0] ln, input logic m16);
        logic [31:0] res;
        res = old;
        if (m16) begin
            if (ln[1]) res[15:0] = d;
            else res[31:16] = d;
        end else begin
            res[8*(3-ln) +: 8] = d[7:0];
        end
        merge = res;
    endfunction

    // Commit strobe and the merged quadlet it writes
    logic        commit;
    logic [31:0] commitVal;
    assign commit    = accessStart && allowed && !bus.write_n && bus.addr[8];
    assign commitVal = merge(shadow_ff, bus.dataFromHost, lane, bus.mode16);

    // Direct register file, one cycle quadlet commit
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < 64; i++) begin
                regFile_ff[i] <= 32'h00000000;
            end
        end else if (commit && directHit) begin
            regFile_ff[regOfs[7:2]] <= commitVal;
        end
    end

    // Indirect space through index and data pair
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < IND_DEPTH; i++) begin
                indMem_ff[i] <= 32'h00000000;
            end
        end else if (commit && regOfs == OFS_IND_DATA) begin
            indMem_ff[indIndex] <= commitVal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer holding register toward the transmit queue, drained at once
    // A commit in the push cycle reloads the holder and wins over the clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            txHold_ff     <= 32'h00000000;
            txHoldFull_ff <= 1'b0;
        end else if (commit && regOfs == OFS_TX_QUEUE) begin
            txHold_ff     <= commitVal;
            txHoldFull_ff <= 1'b1;
        end else begin
            txHoldFull_ff <= 1'b0;
        end
    end

    // Outputs toward the queues and the interrupt enables
    assign txQueueData    = txHold_ff;
    assign txQueuePush    = txHoldFull_ff;
    // Pop only when the head was really moved into the shadow
    assign rxQueuePop     = accessStart && allowed && !bus.read_n && bus.addr[8]
                            && regOfs == OFS_RX_QUEUE && rxQueueValid;
    assign asyncIrqEnable = regFile_ff[OFS_ASYNC_IRQ_EN[7:2]];
endmodule
`default_nettype wire

/* src/srhp_host.sv */
// Host end: turns Avalon-MM commands into CPU bus cycles on the parallel port.
// Assumes the device answers through its stretch output.
`timescale 1ns/1ps
`default_nettype none
module srhp_host
    import srhp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    srhp_if.host             bus
);
    ////////////////////////////////////////////////////////////////////////
    srhp_host_state_e state_ff;
    logic [11:0]      cmd_ff;
    logic [15:0]      wdata_ff;
    logic [15:0]      rdata_ff;
    logic             busy;
    logic             done_ff;

    assign busy = (state_ff != HST_IDLE);

    // Avalon slave answers after one wait cycle for reads and writes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cmd_ff   <= 12'h000;
            wdata_ff <= 16'h0000;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == CSR_WDATA) wdata_ff <= avs_writedata[15:0];
            if (avs_address == CSR_CMD) cmd_ff <= avs_writedata[11:0];
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !done_ff;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) done_ff <= 1'b0;
        else done_ff <= (avs_read || avs_write) && !done_ff;
    end
    always_comb begin
        unique case (avs_address)
            CSR_CMD:    avs_readdata = {20'h00000, cmd_ff};
            CSR_WDATA:  avs_readdata = {16'h0000, wdata_ff};
            CSR_RDATA:  avs_readdata = {16'h0000, rdata_ff};
            CSR_STATUS: avs_readdata = {31'h0, busy};
            default:    avs_readdata = 32'h00000000;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer, started by a write to the command register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff <= HST_IDLE;
            rdata_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                HST_IDLE:   if (avs_write && !avs_waitrequest && avs_address == CSR_CMD) state_ff <= HST_ADDR;
                HST_ADDR:   state_ff <= HST_STROBE;
                HST_STROBE: if (!bus.hostCycleStretch) begin
                    rdata_ff <= bus.mode16 ? bus.dataFromDev : {8'h00, bus.dataFromDev[7:0]};
                    state_ff <= HST_DONE;
                end
                HST_DONE:   state_ff <= HST_IDLE;
            endcase
        end
    end
    assign bus.muxMode        = cmd_ff[CMD_MUX_BIT];
    assign bus.mode16         = cmd_ff[CMD_MODE16_BIT];
    assign bus.addr           = cmd_ff[8:0];
    assign bus.addrLatch      = bus.muxMode && state_ff == HST_ADDR;
    assign bus.chipSel_n      = !(state_ff == HST_STROBE);
    assign bus.read_n         = !(state_ff == HST_STROBE && !cmd_ff[CMD_WRITE_BIT]);
    assign bus.write_n        = !(state_ff == HST_STROBE && cmd_ff[CMD_WRITE_BIT]);
    assign bus.dataFromHost   = wdata_ff;
    assign bus.dataFromHostEn = !bus.write_n;
endmodule
`default_nettype wire

/* src/srhp_if.sv */
// Parallel CPU bus between the host controller and the device port.
// Assumes the testbench resolves the shared data bus from the enables.
`timescale 1ns/1ps
`default_nettype none
interface srhp_if;
    logic        chipSel_n;
    logic        read_n;
    logic        write_n;
    logic        addrLatch;
    logic        muxMode;
    logic        mode16;
    logic [8:0]  addr;
    logic [15:0] dataFromHost;
    logic        dataFromHostEn;
    logic [15:0] dataFromDev;
    logic        dataFromDevEn;
    logic        hostCycleStretch;

    modport host (output chipSel_n, read_n, write_n, addrLatch, muxMode, mode16, addr,
                  dataFromHost, dataFromHostEn, input dataFromDev, dataFromDevEn, hostCycleStretch);
    modport dev  (input chipSel_n, read_n, write_n, addrLatch, muxMode, mode16, addr,
                  dataFromHost, dataFromHostEn, output dataFromDev, dataFromDevEn, hostCycleStretch);
endinterface
`default_nettype wire

/* src/srhp_pkg.sv */
// Shared constants and types for the shadow register host port.
// Assumes a single 125 MHz clock and synchronous active-low reset on both ends.
package srhp_pkg;
    localparam int          ADDR_W            = 9;
    localparam int          REG_IDX_W         = 6;
    localparam logic [7:0]  OFS_ASYNC_IRQ_EN  = 8'hA4;
    localparam logic [7:0]  OFS_POWER_DOWN    = 8'hB0;
    localparam logic [7:0]  OFS_SHADOW        = 8'hF4;
    localparam logic [7:0]  OFS_IND_INDEX     = 8'hF8;
    localparam logic [7:0]  OFS_IND_DATA      = 8'hFC;
    localparam logic [7:0]  OFS_RX_QUEUE      = 8'h80;
    localparam logic [7:0]  OFS_TX_QUEUE      = 8'h84;
    localparam logic [31:0] SHADOW_PRESET     = 32'h0F0A0500;
    localparam int          IND_DEPTH         = 64;
    localparam int          RXQ_DEPTH         = 16;
    localparam int          CLK_PERIOD_NS     = 8;
    localparam int          STRETCH_NS        = 120;
    localparam int          STRETCH_CYC       = STRETCH_NS / CLK_PERIOD_NS;
    localparam int          FAST_CYC          = 1;
    // Avalon command register map of the host controller
    localparam logic [3:0]  CSR_CMD           = 4'h0;
    localparam logic [3:0]  CSR_WDATA         = 4'h4;
    localparam logic [3:0]  CSR_RDATA         = 4'h8;
    localparam logic [3:0]  CSR_STATUS        = 4'hC;
    localparam int          CMD_ADDR_LSB      = 0;
    localparam int          CMD_WRITE_BIT     = 9;
    localparam int          CMD_MODE16_BIT    = 10;
    localparam int          CMD_MUX_BIT       = 11;

    typedef enum logic [3:0] {
        HST_IDLE   = 4'b0001,
        HST_ADDR   = 4'b0010,
        HST_STROBE = 4'b0100,
        HST_DONE   = 4'b1000
    } srhp_host_state_e;

    // Byte lane selector used by the device end
    function automatic logic [1:0] srhp_lane(input logic [1:0] addrLow, input logic mode16);
        srhp_lane = mode16 ? {addrLow[1], 1'b0} : addrLow;
    endfunction
endpackage

/* verification/srhp_assertions.sv */
// Checker for the CPU bus joining the host end and the device end.
// Assumes it sits beside the interface, fed with its signals by name.
`timescale 1ns/1ps
`default_nettype none
module srhp_assertions (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        chipSel_n,
    input wire logic        read_n,
    input wire logic        write_n,
    input wire logic        muxMode,
    input wire logic [8:0]  addr,
    input wire logic [15:0] dataFromDev,
    input wire logic        dataFromDevEn,
    input wire logic        hostCycleStretch
);
    logic act;
    logic actPrev_ff;
    // Access level and its value one cycle back
    assign act = !chipSel_n && (!read_n || !write_n);
    always_ff @(posedge clk_sys) begin
        actPrev_ff <= reset_n && act;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_slow_stretch_held: assert property (act && !actPrev_ff && addr[8] |=> hostCycleStretch[*8])
        else $error("stretch dropped early on update access");
    chk_slow_stretch_ends: assert property (act && !actPrev_ff && addr[8] |-> ##[9:17] !hostCycleStretch)
        else $error("stretch too long on update access");
    chk_fast_stretch_ends: assert property (act && !actPrev_ff && !addr[8] |-> ##[1:3] !hostCycleStretch)
        else $error("stretch too long on plain access");
    chk_stretch_stays_low: assert property (act && $fell(hostCycleStretch) |=> !act || !hostCycleStretch)
        else $error("stretch rose again within access");
    chk_drive_on_read: assert property (!muxMode && !chipSel_n && !read_n |-> dataFromDevEn)
        else $error("device not driving during read");
    chk_drive_off_idle: assert property (read_n |-> !dataFromDevEn)
        else $error("device driving outside read");
    chk_plain_read_stable: assert property (actPrev_ff && !read_n && !$past(read_n) && !addr[8] && $stable(addr)
        && dataFromDevEn && $past(dataFromDevEn) |-> $stable(dataFromDev))
        else $error("plain read changed data");
    chk_one_strobe_only: assert property (read_n || write_n)
        else $error("read and write strobes low together");
    chk_release_bound: assert property (act && $fell(hostCycleStretch) |-> ##[1:4] !act)
        else $error("host held strobes after answer");
    chk_gap_idle: assert property (actPrev_ff && !act |=> !act)
        else $error("no idle cycle between accesses");
    cover property (act && !actPrev_ff && addr[8] && !write_n);
    cover property (act && !actPrev_ff && addr[8] && !read_n);
    cover property (act && muxMode);
endmodule
`default_nettype wire

/* verification/tb_shadow_register_host_port.sv */
// Self-checking bench: host and device ends joined over the CPU bus.
// Assumes the Avalon command map of srhp_pkg; expectations come from a shadow model.
`timescale 1ns/1ps
`default_nettype none
module tb_shadow_register_host_port;
    import srhp_pkg::*;
    logic        clk_sys;
    logic        reset_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        powerDownPin;
    logic [31:0] rxQueueData;
    logic        rxQueueValid;
    logic        rxQueuePop;
    logic [31:0] txQueueData;
    logic        txQueuePush;
    logic [31:0] asyncIrqEnable;
    logic [31:0] sh;
    logic [31:0] irqM;
    logic [31:0] indM;
    logic [31:0] pushData;
    logic        pdSw;
    logic        act;
    logic        actPrev = 1'b0;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          pushCount = 0;
    int          popCount = 0;
    int          cpuCount = 0;

    srhp_if bus ();
    srhp_host srhp_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus));
    srhp_device srhp_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .powerDownPin(powerDownPin),
        .rxQueueData(rxQueueData), .rxQueueValid(rxQueueValid), .rxQueuePop(rxQueuePop),
        .txQueueData(txQueueData), .txQueuePush(txQueuePush), .asyncIrqEnable(asyncIrqEnable));
    srhp_assertions srhp_assertions_inst (.clk_sys(clk_sys), .reset_n(reset_n), .chipSel_n(bus.chipSel_n),
        .read_n(bus.read_n), .write_n(bus.write_n), .muxMode(bus.muxMode), .addr(bus.addr),
        .dataFromDev(bus.dataFromDev), .dataFromDevEn(bus.dataFromDevEn), .hostCycleStretch(bus.hostCycleStretch));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, cycle and pulse counters, hang limit
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    assign act = !bus.chipSel_n && (!bus.read_n || !bus.write_n);
    always @(posedge clk_sys) begin
        actPrev <= act;
        cpuCount <= cpuCount + int'(act && !actPrev);
        pushCount <= pushCount + int'(txQueuePush);
        popCount <= popCount + int'(rxQueuePop);
        if (txQueuePush) pushData <= txQueueData;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lane helpers: byte lane 0 is the top byte, word lane 0 the upper half
    function automatic logic [31:0] put(logic [31:0] q, logic m16, logic [1:0] a, logic [15:0] d);
        if (m16) q[(a[1] ? 0 : 16) +: 16] = d;
        else q[(3 - a) * 8 +: 8] = d[7:0];
        return q;
    endfunction
    function automatic logic [15:0] get(logic [31:0] q, logic m16, logic [1:0] a);
        return m16 ? q[(a[1] ? 0 : 16) +: 16] : {8'h00, q[(3 - a) * 8 +: 8]};
    endfunction
    function automatic logic [8:0] ad(logic u, logic [7:0] o, logic [1:0] l);
        return {u, o[7:2], l};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One Avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic av(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // One CPU cycle through the host, mux mode drawn at random; reads compared to the model
    task automatic acc(input logic wr, input logic m16, input logic [8:0] adr, input logic [15:0] d);
        logic [31:0] t;
        logic        pd;
        logic        u;
        int          n;
        n = cpuCount;
        u = adr[8];
        av(1'b1, CSR_WDATA, {16'h0000, d}, t);
        av(1'b1, CSR_CMD, {20'h00000, 1'($urandom_range(1)), m16, wr, adr}, t);
        while (cpuCount == n || act) @(negedge clk_sys);
        @(posedge clk_sys);
        av(1'b0, CSR_STATUS, 32'h0, t);
        check("host busy", t, 32'h0);
        av(1'b0, CSR_RDATA, 32'h0, t);
        pd = (powerDownPin || pdSw) && adr[7:2] != OFS_POWER_DOWN[7:2];
        if (pd) return;
        if (wr) begin
            sh = put(sh, m16, adr[1:0], d);
            if (u && adr[7:2] == OFS_ASYNC_IRQ_EN[7:2]) irqM = sh;
            if (u && adr[7:2] == OFS_IND_DATA[7:2]) indM = sh;
            if (u && adr[7:2] == OFS_POWER_DOWN[7:2]) pdSw = sh[0];
        end else begin
            if (u && adr[7:2] == OFS_ASYNC_IRQ_EN[7:2]) sh = irqM;
            if (u && adr[7:2] == OFS_RX_QUEUE[7:2]) sh = rxQueueData;
            if (u && adr[7:2] == OFS_IND_DATA[7:2]) sh = indM;
            check("cpu read", m16 ? {16'h0, t[15:0]} : {24'h0, t[7:0]}, {16'h0, get(sh, m16, adr[1:0])});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int k;
        logic m;
        reset_n = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {powerDownPin, rxQueueData, rxQueueValid, pdSw} = '0;
        {irqM, indM} = '0;
        sh = SHADOW_PRESET;
        void'($urandom(24));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        // Preset pattern read through four byte lanes and two word lanes
        for (int i = 0; i < 6; i++) acc(1'b0, i > 3, ad(0, OFS_SHADOW, i > 3 ? {i[0], 1'b0} : i[1:0]), 16'h0);
        // Scattered byte writes, each lane once, nothing committed yet
        for (int j = 0; j < 4; j++) acc(1'b1, 1'b0, ad(0, OFS_ASYNC_IRQ_EN, 2'(j * 3 % 4)), 16'($urandom));
        check("irq no commit", asyncIrqEnable, irqM);
        acc(1'b1, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'($urandom));
        check("irq commit", asyncIrqEnable, irqM);
        // Random partial rewrites, committed on a random lane in either width
        repeat (24) begin
            m = 1'($urandom_range(1));
            repeat ($urandom_range(3)) acc(1'b1, m, ad(0, OFS_ASYNC_IRQ_EN, 2'($urandom)), 16'($urandom));
            acc(1'b1, m, ad(1, OFS_ASYNC_IRQ_EN, 2'($urandom)), 16'($urandom));
            check("irq partial", asyncIrqEnable, irqM);
            acc(1'b0, m, ad(0, OFS_SHADOW, 2'($urandom)), 16'h0);
        end
        // Disturb the shadow, snapshot the whole register through one byte read, write only that byte back
        acc(1'b1, 1'b0, ad(0, OFS_SHADOW, 0), 16'h00A5);
        acc(1'b0, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'h0);
        acc(1'b1, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'($urandom));
        check("irq one byte", asyncIrqEnable, irqM);
        // Quadlet into the transmit queue through the transfer register
        k = pushCount;
        acc(1'b1, 1'b1, ad(0, OFS_TX_QUEUE, 0), 16'($urandom));
        acc(1'b1, 1'b1, ad(1, OFS_TX_QUEUE, 2), 16'($urandom));
        check("push count", 32'(pushCount - k), 32'h1);
        check("push data", pushData, sh);
        // Receive queue head moved into the shadow and popped once
        rxQueueData <= $urandom;
        rxQueueValid <= 1'b1;
        k = popCount;
        @(posedge clk_sys);
        acc(1'b0, 1'b0, ad(1, OFS_RX_QUEUE, 0), 16'h0);
        acc(1'b0, 1'b0, ad(0, OFS_SHADOW, 3), 16'h0);
        check("pop count", 32'(popCount - k), 32'h1);
        rxQueueValid <= 1'b0;
        // Indirect entry written through index and data, then read back
        acc(1'b1, 1'b1, ad(0, OFS_IND_INDEX, 0), 16'h0);
        acc(1'b1, 1'b1, ad(1, OFS_IND_INDEX, 2), 16'($urandom_range(63)));
        acc(1'b1, 1'b1, ad(0, OFS_IND_DATA, 0), 16'($urandom));
        acc(1'b1, 1'b1, ad(1, OFS_IND_DATA, 2), 16'($urandom));
        acc(1'b0, 1'b1, ad(1, OFS_IND_DATA, 0), 16'h0);
        acc(1'b0, 1'b1, ad(0, OFS_SHADOW, 2), 16'h0);
        // Power down by pin, then by the software bit, leaving only that register open
        powerDownPin <= 1'b1;
        acc(1'b1, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'($urandom));
        check("irq pin down", asyncIrqEnable, irqM);
        powerDownPin <= 1'b0;
        acc(1'b1, 1'b1, ad(0, OFS_POWER_DOWN, 0), 16'h0);
        acc(1'b1, 1'b1, ad(1, OFS_POWER_DOWN, 2), 16'h0001);
        acc(1'b1, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'($urandom));
        check("irq soft down", asyncIrqEnable, irqM);
        acc(1'b1, 1'b1, ad(1, OFS_POWER_DOWN, 2), 16'h0000);
        acc(1'b1, 1'b0, ad(1, OFS_ASYNC_IRQ_EN, 3), 16'($urandom));
        check("irq powered up", asyncIrqEnable, irqM);
        tally_and_finish();
    end
endmodule
`default_nettype wire
